// *** core/mmvb_arb.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// round robin between the two link ports
// ----------------------------------------
module mmvb_arb (
  input wire logic clk,
  input wire logic rst,
  input wire logic eth_valid,
  output logic eth_ready,
  input wire logic [7:0] eth_func,
  input wire logic [15:0] eth_start,
  input wire logic [15:0] eth_count,
  input wire logic ser_valid,
  output logic ser_ready,
  input wire logic [7:0] ser_func,
  input wire logic [15:0] ser_start,
  input wire logic [15:0] ser_count,
  mmvb_req_if.src rq
);
  logic last_ser_r;
  logic grant_ser;
  assign grant_ser = ser_valid & (~eth_valid | ~last_ser_r);
  assign rq.valid = eth_valid | ser_valid;
  assign rq.port = grant_ser;
  assign rq.func = grant_ser ? ser_func : eth_func;
  assign rq.start = grant_ser ? ser_start : eth_start;
  assign rq.count = grant_ser ? ser_count : eth_count;
  assign eth_ready = rq.ready & ~grant_ser;
  assign ser_ready = rq.ready & grant_ser;
  always_ff @(posedge clk) begin
    if (rst) begin
      last_ser_r <= 1'b0;
    end else if (rq.valid & rq.ready) begin
      last_ser_r <= grant_ser;
    end
  end
endmodule

// *** core/mmvb_pkg.sv ***
package mmvb_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int REG_W = 16;
  localparam int VALUE_W = 32;
  localparam int IDX_W = 6;
  localparam int NUM_VALUES = 48;
  localparam int PROF_FLAGS_W = 3;
  // ----------------------------------------
  // value offsets, first register of each
  // ----------------------------------------
  localparam logic [15:0] OFS_VOLT_PHASE1_NEUTRAL = 16'h0001;
  localparam logic [15:0] OFS_VOLT_PHASE2_NEUTRAL = 16'h0003;
  localparam logic [15:0] OFS_VOLT_PHASE3_NEUTRAL = 16'h0005;
  localparam logic [15:0] OFS_VOLT_PHASE1_PHASE2 = 16'h0007;
  localparam logic [15:0] OFS_VOLT_PHASE2_PHASE3 = 16'h0009;
  localparam logic [15:0] OFS_VOLT_PHASE3_PHASE1 = 16'h000B;
  localparam logic [15:0] OFS_CURRENT_PHASE1 = 16'h000D;
  localparam logic [15:0] OFS_CURRENT_PHASE2 = 16'h000F;
  localparam logic [15:0] OFS_CURRENT_PHASE3 = 16'h0011;
  localparam logic [15:0] OFS_APPARENT_PWR_PHASE1 = 16'h0013;
  localparam logic [15:0] OFS_APPARENT_PWR_PHASE2 = 16'h0015;
  localparam logic [15:0] OFS_APPARENT_PWR_PHASE3 = 16'h0017;
  localparam logic [15:0] OFS_ACTIVE_PWR_PHASE1 = 16'h0019;
  localparam logic [15:0] OFS_ACTIVE_PWR_PHASE2 = 16'h001B;
  localparam logic [15:0] OFS_ACTIVE_PWR_PHASE3 = 16'h001D;
  localparam logic [15:0] OFS_REACTIVE_PWR_PHASE1 = 16'h001F;
  localparam logic [15:0] OFS_REACTIVE_PWR_PHASE2 = 16'h0021;
  localparam logic [15:0] OFS_REACTIVE_PWR_PHASE3 = 16'h0023;
  localparam logic [15:0] OFS_PF_PHASE1 = 16'h0025;
  localparam logic [15:0] OFS_PF_PHASE2 = 16'h0027;
  localparam logic [15:0] OFS_PF_PHASE3 = 16'h0029;
  localparam logic [15:0] OFS_HARMONIC_DIST_V12 = 16'h002B;
  localparam logic [15:0] OFS_HARMONIC_DIST_V23 = 16'h002D;
  localparam logic [15:0] OFS_HARMONIC_DIST_V31 = 16'h002F;
  localparam logic [15:0] OFS_RESERVED_A = 16'h0031;
  localparam logic [15:0] OFS_RESERVED_B = 16'h0033;
  localparam logic [15:0] OFS_RESERVED_C = 16'h0035;
  localparam logic [15:0] OFS_LINE_FREQUENCY = 16'h0037;
  localparam logic [15:0] OFS_AVG_VOLT_TO_NEUTRAL = 16'h0039;
  localparam logic [15:0] OFS_AVG_VOLT_LINE_TO_LINE = 16'h003B;
  localparam logic [15:0] OFS_AVG_CURRENT = 16'h003D;
  localparam logic [15:0] OFS_TOTAL_APPARENT_PWR = 16'h003F;
  localparam logic [15:0] OFS_TOTAL_ACTIVE_PWR = 16'h0041;
  localparam logic [15:0] OFS_TOTAL_REACTIVE_PWR = 16'h0043;
  localparam logic [15:0] OFS_TOTAL_PF = 16'h0045;
  localparam logic [15:0] OFS_VOLT_IMBALANCE = 16'h0047;
  localparam logic [15:0] OFS_CURRENT_IMBALANCE = 16'h0049;
  localparam logic [15:0] OFS_PEAK_VOLT_PHASE1_NEUTRAL = 16'h004B;
  localparam logic [15:0] OFS_PEAK_VOLT_PHASE2_NEUTRAL = 16'h004D;
  localparam logic [15:0] OFS_PEAK_VOLT_PHASE3_NEUTRAL = 16'h004F;
  localparam logic [15:0] OFS_PEAK_VOLT_PHASE1_PHASE2 = 16'h0051;
  localparam logic [15:0] OFS_PEAK_VOLT_PHASE2_PHASE3 = 16'h0053;
  localparam logic [15:0] OFS_PEAK_VOLT_PHASE3_PHASE1 = 16'h0055;
  localparam logic [15:0] OFS_PEAK_CURRENT_PHASE1 = 16'h0057;
  localparam logic [15:0] OFS_PEAK_CURRENT_PHASE2 = 16'h0059;
  localparam logic [15:0] OFS_PEAK_CURRENT_PHASE3 = 16'h005B;
  localparam logic [15:0] OFS_PEAK_APPARENT_PWR_PHASE1 = 16'h005D;
  localparam logic [15:0] OFS_PEAK_APPARENT_PWR_PHASE2 = 16'h005F;
  localparam logic [15:0] FIRST_OFFSET = OFS_VOLT_PHASE1_NEUTRAL;
  localparam logic [15:0] LAST_OFFSET = OFS_PEAK_APPARENT_PWR_PHASE2 + 16'h0001;
  // ----------------------------------------
  // function and exception codes, limits
  // ----------------------------------------
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] EXC_READ_ONLY = 8'h01;
  localparam logic [15:0] MAX_READ_COUNT = 16'h007D;
  localparam logic [15:0] MAX_WRITE_COUNT = 16'h007B;
  localparam logic [15:0] SINGLE_WRITE_COUNT = 16'h0001;
  // ----------------------------------------
  // load profile flags, reset values
  // ----------------------------------------
  localparam int PROF_UNCERTAIN_BIT = 0;
  localparam int PROF_SUPPLY_BIT = 1;
  localparam int PROF_REALIGN_BIT = 2;
  localparam logic [2:0] PROF_RESET = 3'h0;
  localparam logic [31:0] VALUE_RESET = 32'h0;
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_READ, S_EXC} mmvb_state_type;
endpackage

// *** core/mmvb_prof.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// per period load profile flags
// ----------------------------------------
module mmvb_prof (
  input wire logic clk,
  input wire logic rst,
  input wire logic period_end,
  input wire logic cut_supply,
  input wire logic cut_resync,
  input wire logic uncertain_evt,
  input wire logic time_evt,
  output logic [2:0] flags,
  output logic strobe
);
  logic unc_pend_r, time_pend_r, strobe_r;
  logic [2:0] flags_r, flags_nxt;
  assign flags_nxt[mmvb_pkg::PROF_UNCERTAIN_BIT] = unc_pend_r | uncertain_evt;
  assign flags_nxt[mmvb_pkg::PROF_SUPPLY_BIT] = cut_supply;
  assign flags_nxt[mmvb_pkg::PROF_REALIGN_BIT] = cut_resync | time_pend_r | time_evt;
  assign flags = flags_r;
  assign strobe = strobe_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      unc_pend_r <= 1'b0;
      time_pend_r <= 1'b0;
      flags_r <= mmvb_pkg::PROF_RESET;
      strobe_r <= 1'b0;
    end else begin
      unc_pend_r <= ~period_end & (unc_pend_r | uncertain_evt);
      time_pend_r <= ~period_end & (time_pend_r | time_evt);
      strobe_r <= period_end;
      if (period_end) begin
        flags_r <= flags_nxt;
      end
    end
  end
endmodule

// *** core/mmvb_req_if.sv ***
`timescale 1ns/100ps
interface mmvb_req_if;
  logic valid;
  logic ready;
  logic port;
  logic [7:0] func;
  logic [15:0] start;
  logic [15:0] count;
  modport src (output valid, port, func, start, count, input ready);
  modport dst (input valid, port, func, start, count, output ready);
endinterface

// *** core/mmvb_top.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// measured value register bank
// ----------------------------------------
// Function
// - a read starting on the second register of a value gets an exception, no data.
// - a write whose span ends inside a value gets an exception, nothing is updated.
// - function codes 0x03 and 0x04 both read the measured values.
// - each value is a read-only float in two registers starting at an odd offset.
// - the profile flag set is recorded once per demand period.
// - the uncertain flag is true when the period values are not certain.
// - the supply loss flag is true when supply failure cut the period short.
// - the realigned flag is true on a resync cut or an uncertain time base.
// - values are reachable from both the Ethernet and the serial link port.
module mmvb_top #(
  parameter int NUM_VALUES = mmvb_pkg::NUM_VALUES
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic ETH_REQ_VALID,
  output logic ETH_REQ_READY,
  input wire logic [7:0] ETH_REQ_FUNC,
  input wire logic [15:0] ETH_REQ_START,
  input wire logic [15:0] ETH_REQ_COUNT,
  input wire logic SER_REQ_VALID,
  output logic SER_REQ_READY,
  input wire logic [7:0] SER_REQ_FUNC,
  input wire logic [15:0] SER_REQ_START,
  input wire logic [15:0] SER_REQ_COUNT,
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output logic RSP_PORT,
  output logic RSP_EXC,
  output logic [7:0] RSP_FUNC,
  output logic [7:0] RSP_CODE,
  output logic [15:0] RSP_DATA,
  output logic RSP_LAST,
  input wire logic MEAS_WE,
  input wire logic [5:0] MEAS_IDX,
  input wire logic [31:0] MEAS_DATA,
  input wire logic PERIOD_END,
  input wire logic PERIOD_CUT_SUPPLY,
  input wire logic PERIOD_CUT_RESYNC,
  input wire logic VALUES_UNCERTAIN,
  input wire logic TIME_UNCERTAIN,
  output logic [2:0] PROFILE_FLAGS,
  output logic PROFILE_STROBE,
  output logic [15:0] REQ_TOTAL,
  output logic [15:0] EXC_TOTAL
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [5:0] reg_index(input logic [15:0] addr);
    logic [15:0] rel;
    rel = addr - mmvb_pkg::FIRST_OFFSET;
    return rel[6:1];
  endfunction

  function automatic logic first_reg(input logic [15:0] addr);
    return addr[0];
  endfunction

  localparam logic [5:0] RSVD_LO = reg_index(mmvb_pkg::OFS_RESERVED_A);
  localparam logic [5:0] RSVD_HI = reg_index(mmvb_pkg::OFS_RESERVED_C);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  mmvb_req_if rq ();
  mmvb_pkg::mmvb_state_type state_r, state_nxt;
  logic port_r;
  logic [7:0] func_r;
  logic [15:0] start_r;
  logic [15:0] count_r;
  logic [15:0] ptr_r, ptr_nxt;
  logic [15:0] left_r, left_nxt;
  logic [15:0] data_r, data_nxt;
  logic [15:0] hold_r;
  logic last_r, last_nxt;
  logic exc_r;
  logic [7:0] code_r;
  logic [7:0] rsp_func_r;
  logic [15:0] req_total_r;
  logic [15:0] exc_total_r;
  logic [31:0] value_mem_r [NUM_VALUES];

  logic take;
  logic beat;
  logic in_check;
  logic is_read;
  logic is_wr_single;
  logic is_wr_multi;
  logic is_write;
  logic [15:0] span;
  logic [16:0] last_addr;
  logic count_ok;
  logic range_ok;
  logic start_aligned;
  logic end_aligned;
  logic [7:0] exc_code;
  logic check_fail;
  logic [15:0] rd_addr;
  logic [5:0] rd_idx;
  logic rd_hi;
  logic rd_rsvd;
  logic [31:0] rd_value;
  logic [15:0] rd_word;
  logic load_word;
  logic meas_ok;
  logic meas_rsvd;

  // ----------------------------------------
  // link ports and profile recorder
  // ----------------------------------------
  mmvb_arb u_arb (
    .clk(SYS_CLK),
    .rst(RST),
    .eth_valid(ETH_REQ_VALID),
    .eth_ready(ETH_REQ_READY),
    .eth_func(ETH_REQ_FUNC),
    .eth_start(ETH_REQ_START),
    .eth_count(ETH_REQ_COUNT),
    .ser_valid(SER_REQ_VALID),
    .ser_ready(SER_REQ_READY),
    .ser_func(SER_REQ_FUNC),
    .ser_start(SER_REQ_START),
    .ser_count(SER_REQ_COUNT),
    .rq(rq.src)
  );

  mmvb_prof u_prof (
    .clk(SYS_CLK),
    .rst(RST),
    .period_end(PERIOD_END),
    .cut_supply(PERIOD_CUT_SUPPLY),
    .cut_resync(PERIOD_CUT_RESYNC),
    .uncertain_evt(VALUES_UNCERTAIN),
    .time_evt(TIME_UNCERTAIN),
    .flags(PROFILE_FLAGS),
    .strobe(PROFILE_STROBE)
  );

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  assign rq.ready = (state_r == mmvb_pkg::S_IDLE);
  assign take = rq.valid & rq.ready;
  assign in_check = (state_r == mmvb_pkg::S_CHECK);
  assign is_read = (func_r == mmvb_pkg::FC_READ_HOLD)
    | (func_r == mmvb_pkg::FC_READ_INPUT);
  assign is_wr_single = (func_r == mmvb_pkg::FC_WRITE_SINGLE);
  assign is_wr_multi = (func_r == mmvb_pkg::FC_WRITE_MULTI);
  assign is_write = is_wr_single | is_wr_multi;
  assign span = is_wr_single ? mmvb_pkg::SINGLE_WRITE_COUNT : count_r;
  assign last_addr = {1'b0, start_r} + {1'b0, span} - 17'h00001;

  assign count_ok = (span != 16'h0000)
    & (is_write ? (span <= mmvb_pkg::MAX_WRITE_COUNT)
                : (span <= mmvb_pkg::MAX_READ_COUNT));
  assign range_ok = (start_r >= mmvb_pkg::FIRST_OFFSET)
    & (last_addr <= {1'b0, mmvb_pkg::LAST_OFFSET});
  assign start_aligned = first_reg(start_r);
  assign end_aligned = ~first_reg(last_addr[15:0]);

  // ----------------------------------------
  // exception selection, first match wins
  // ----------------------------------------
  always_comb begin
    exc_code = mmvb_pkg::EXC_NONE;
    if (!is_read && !is_write) begin
      exc_code = mmvb_pkg::EXC_ILLEGAL_FUNC;
    end else if (!count_ok) begin
      exc_code = mmvb_pkg::EXC_ILLEGAL_VALUE;
    end else if (!range_ok) begin
      exc_code = mmvb_pkg::EXC_ILLEGAL_ADDR;
    end else if (!start_aligned) begin
      exc_code = mmvb_pkg::EXC_ILLEGAL_ADDR;
    end else if (is_write && !end_aligned) begin
      exc_code = mmvb_pkg::EXC_ILLEGAL_ADDR;
    end else if (is_write) begin
      exc_code = mmvb_pkg::EXC_READ_ONLY;
    end
  end

  assign check_fail = (exc_code != mmvb_pkg::EXC_NONE);

  // ----------------------------------------
  // read path
  // ----------------------------------------
  assign rd_addr = in_check ? start_r : ptr_r + 16'h0001;
  assign rd_idx = reg_index(rd_addr);
  assign rd_hi = first_reg(rd_addr);
  assign rd_rsvd = (rd_idx >= RSVD_LO) & (rd_idx <= RSVD_HI);
  assign rd_value = value_mem_r[rd_idx];

  // low word comes from the copy taken with the high word, no tearing
  always_comb begin
    rd_word = 16'h0000;
    if (rd_rsvd) begin
      rd_word = 16'h0000;
    end else if (rd_hi) begin
      rd_word = rd_value[31:16];
    end else if (!in_check) begin
      rd_word = hold_r;
    end else begin
      rd_word = rd_value[15:0];
    end
  end

  assign beat = RSP_VALID & RSP_READY;
  assign load_word = in_check
    | ((state_r == mmvb_pkg::S_READ) & beat & (left_r != 16'h0001));

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mmvb_pkg::S_IDLE: begin
        if (take) begin
          state_nxt = mmvb_pkg::S_CHECK;
        end
      end
      mmvb_pkg::S_CHECK: begin
        state_nxt = check_fail ? mmvb_pkg::S_EXC : mmvb_pkg::S_READ;
      end
      mmvb_pkg::S_READ: begin
        if (beat && left_r == 16'h0001) begin
          state_nxt = mmvb_pkg::S_IDLE;
        end
      end
      mmvb_pkg::S_EXC: begin
        if (beat) begin
          state_nxt = mmvb_pkg::S_IDLE;
        end
      end
    endcase
  end

  assign ptr_nxt = in_check ? start_r
    : (beat ? ptr_r + 16'h0001 : ptr_r);
  assign left_nxt = in_check ? span
    : ((beat && state_r == mmvb_pkg::S_READ) ? left_r - 16'h0001 : left_r);
  assign last_nxt = in_check ? ((span == 16'h0001) & ~check_fail)
    : ((beat && state_r == mmvb_pkg::S_READ) ? (left_r == 16'h0002) : last_r);
  assign data_nxt = load_word ? rd_word : data_r;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_r <= mmvb_pkg::S_IDLE;
      ptr_r <= 16'h0000;
      left_r <= 16'h0000;
      last_r <= 1'b0;
      data_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      left_r <= left_nxt;
      last_r <= last_nxt;
      data_r <= data_nxt;
    end
  end

  // ----------------------------------------
  // request latch
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      port_r <= 1'b0;
      func_r <= 8'h00;
      start_r <= 16'h0000;
      count_r <= 16'h0000;
    end else if (take) begin
      port_r <= rq.port;
      func_r <= rq.func;
      start_r <= rq.start;
      count_r <= rq.count;
    end
  end

  // ----------------------------------------
  // answer header
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      exc_r <= 1'b0;
      code_r <= mmvb_pkg::EXC_NONE;
      rsp_func_r <= 8'h00;
    end else if (in_check) begin
      exc_r <= check_fail;
      code_r <= exc_code;
      rsp_func_r <= check_fail ? (func_r | mmvb_pkg::EXC_FLAG) : func_r;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      hold_r <= 16'h0000;
    end else if (load_word && rd_hi) begin
      hold_r <= rd_value[15:0];
    end
  end

  // ----------------------------------------
  // request and exception totals
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      req_total_r <= 16'h0000;
      exc_total_r <= 16'h0000;
    end else begin
      if (take) begin
        req_total_r <= req_total_r + 16'h0001;
      end
      if (in_check && check_fail) begin
        exc_total_r <= exc_total_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // value store, updated only by measurement
  // ----------------------------------------
  assign meas_rsvd = (MEAS_IDX >= RSVD_LO) & (MEAS_IDX <= RSVD_HI);
  assign meas_ok = MEAS_WE & ~meas_rsvd & (32'(MEAS_IDX) < NUM_VALUES);

  for (genvar g = 0; g < NUM_VALUES; g++) begin : g_val
    always_ff @(posedge SYS_CLK) begin
      if (RST) begin
        value_mem_r[g] <= mmvb_pkg::VALUE_RESET;
      end else if (meas_ok && MEAS_IDX == 6'(g)) begin
        value_mem_r[g] <= MEAS_DATA;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RSP_VALID = (state_r == mmvb_pkg::S_READ) | (state_r == mmvb_pkg::S_EXC);
  assign RSP_PORT = port_r;
  assign RSP_EXC = exc_r;
  assign RSP_FUNC = rsp_func_r;
  assign RSP_CODE = code_r;
  assign RSP_DATA = data_r;
  assign RSP_LAST = last_r;
  assign REQ_TOTAL = req_total_r;
  assign EXC_TOTAL = exc_total_r;
endmodule

// *** verif/mmvb_master.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// link master, one request at a time
// ----------------------------------------
module mmvb_master (
  input wire logic clk,
  output logic [1:0] valid,
  input wire logic [1:0] ready,
  output logic [7:0] func,
  output logic [15:0] start,
  output logic [15:0] count,
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic rsp_port,
  input wire logic rsp_exc,
  input wire logic rsp_last,
  input wire logic [7:0] rsp_func,
  input wire logic [7:0] rsp_code,
  input wire logic [15:0] rsp_data
);
  logic slow = 1'h0;
  logic got_port;
  logic got_exc;
  logic [7:0] got_func;
  logic [7:0] got_code;
  logic [15:0] beats[$];
  initial begin
    valid = 2'h0;
    rsp_ready = 1'h0;
    func = 8'h00;
    start = 16'h0000;
    count = 16'h0000;
  end
  // request held until taken, released lines inverted
  task automatic xfer(input logic p, input logic [7:0] f, input logic [15:0] s,
    input logic [15:0] c);
    int n;
    logic done;
    beats.delete();
    valid[p] = 1'h1;
    func = f;
    start = s;
    count = c;
    n = 0;
    while (!ready[p] && n < 100) begin
      @(posedge clk);
      #2;
      n++;
    end
    @(posedge clk);
    #2;
    valid = 2'h0;
    func = ~f;
    start = ~s;
    count = ~c;
    n = 0;
    done = 1'h0;
    while (!done && n < 300) begin
      rsp_ready = slow ? ~rsp_ready : 1'h1;
      if (rsp_valid && rsp_ready) begin
        beats.push_back(rsp_data);
        got_port = rsp_port;
        got_exc = rsp_exc;
        got_func = rsp_func;
        got_code = rsp_code;
        done = rsp_last || rsp_exc;
      end
      @(posedge clk);
      #2;
      n++;
    end
    rsp_ready = 1'h0;
  endtask
endmodule

// *** verif/mmvb_top_chk.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// port checker for the value bank
// ----------------------------------------
module mmvb_chk (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic ETH_REQ_VALID,
  input wire logic ETH_REQ_READY,
  input wire logic SER_REQ_VALID,
  input wire logic SER_REQ_READY,
  input wire logic RSP_VALID,
  input wire logic RSP_READY,
  input wire logic RSP_EXC,
  input wire logic RSP_LAST,
  input wire logic [7:0] RSP_FUNC,
  input wire logic [15:0] RSP_DATA,
  input wire logic PERIOD_END,
  input wire logic PERIOD_CUT_SUPPLY,
  input wire logic PERIOD_CUT_RESYNC,
  input wire logic [2:0] PROFILE_FLAGS,
  input wire logic PROFILE_STROBE,
  input wire logic [15:0] REQ_TOTAL,
  input wire logic [15:0] EXC_TOTAL
);
  wire take = (ETH_REQ_VALID && ETH_REQ_READY) || (SER_REQ_VALID && SER_REQ_READY);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_take_busy: assert property (take |=> !ETH_REQ_READY && !SER_REQ_READY)
    else $error("ready high while busy");
  a_answer_lat: assert property (take |=> !RSP_VALID ##1 RSP_VALID)
    else $error("answer not two cycles after take");
  a_stall_hold: assert property (RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_DATA)
    && $stable(RSP_LAST) && $stable(RSP_EXC)) else $error("beat changed under stall");
  a_exc_beat: assert property (RSP_VALID && RSP_EXC |-> !RSP_LAST && RSP_FUNC[7])
    else $error("bad exception beat");
  a_exc_count: assert property ($rose(RSP_VALID && RSP_EXC) |->
    EXC_TOTAL == $past(EXC_TOTAL) + 16'h0001) else $error("exception total off");
  a_req_count: assert property (take |=> REQ_TOTAL == $past(REQ_TOTAL) + 16'h0001)
    else $error("request total off");
  a_strobe_follow: assert property (PERIOD_END |=> PROFILE_STROBE)
    else $error("no strobe after period end");
  a_strobe_cause: assert property ($rose(PROFILE_STROBE) |-> $past(PERIOD_END))
    else $error("strobe without period end");
  a_flags_hold: assert property (!PERIOD_END |=> $stable(PROFILE_FLAGS))
    else $error("flags changed mid period");
  a_supply_flag: assert property (PERIOD_END |=> PROFILE_FLAGS[1] == $past(PERIOD_CUT_SUPPLY))
    else $error("supply loss flag wrong");
  a_resync_flag: assert property (PERIOD_END && PERIOD_CUT_RESYNC |=> PROFILE_FLAGS[2])
    else $error("realigned flag not set");
endmodule
bind mmvb_top mmvb_chk i_mmvb_chk (.SYS_CLK(SYS_CLK), .RST(RST), .ETH_REQ_VALID(ETH_REQ_VALID),
  .ETH_REQ_READY(ETH_REQ_READY), .SER_REQ_VALID(SER_REQ_VALID), .SER_REQ_READY(SER_REQ_READY),
  .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP_EXC(RSP_EXC), .RSP_LAST(RSP_LAST),
  .RSP_FUNC(RSP_FUNC), .RSP_DATA(RSP_DATA), .PERIOD_END(PERIOD_END),
  .PERIOD_CUT_SUPPLY(PERIOD_CUT_SUPPLY), .PERIOD_CUT_RESYNC(PERIOD_CUT_RESYNC),
  .PROFILE_FLAGS(PROFILE_FLAGS), .PROFILE_STROBE(PROFILE_STROBE), .REQ_TOTAL(REQ_TOTAL),
  .EXC_TOTAL(EXC_TOTAL));

// *** verif/mmvb_top_test.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module mmvb_top_test;
  logic sys_clk, rst, rsp_valid, rsp_ready, rsp_port, rsp_exc, rsp_last, strobe;
  logic meas_we, period_end, cut_supply, cut_resync, val_unc, time_unc;
  logic [1:0] req_valid, req_ready;
  logic [7:0] func, rsp_func, rsp_code;
  logic [15:0] start, count, rsp_data, req_total, exc_total;
  logic [5:0] meas_idx;
  logic [31:0] meas_data;
  logic [2:0] flags;
  int n_fail = 0;
  int n_tests = 0;
  int n_exc = 0;
  int n_req = 0;
  int ids[7] = '{0, 1, 2, 23, 24, 27, 47};
  mmvb_top i_mmvb_top (.SYS_CLK(sys_clk), .RST(rst), .ETH_REQ_VALID(req_valid[0]),
    .ETH_REQ_READY(req_ready[0]), .ETH_REQ_FUNC(func), .ETH_REQ_START(start),
    .ETH_REQ_COUNT(count), .SER_REQ_VALID(req_valid[1]), .SER_REQ_READY(req_ready[1]),
    .SER_REQ_FUNC(func), .SER_REQ_START(start), .SER_REQ_COUNT(count),
    .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready), .RSP_PORT(rsp_port), .RSP_EXC(rsp_exc),
    .RSP_FUNC(rsp_func), .RSP_CODE(rsp_code), .RSP_DATA(rsp_data), .RSP_LAST(rsp_last),
    .MEAS_WE(meas_we), .MEAS_IDX(meas_idx), .MEAS_DATA(meas_data), .PERIOD_END(period_end),
    .PERIOD_CUT_SUPPLY(cut_supply), .PERIOD_CUT_RESYNC(cut_resync),
    .VALUES_UNCERTAIN(val_unc), .TIME_UNCERTAIN(time_unc), .PROFILE_FLAGS(flags),
    .PROFILE_STROBE(strobe), .REQ_TOTAL(req_total), .EXC_TOTAL(exc_total));
  mmvb_master i_mmvb_master (.clk(sys_clk), .valid(req_valid), .ready(req_ready),
    .func(func), .start(start), .count(count), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_port(rsp_port), .rsp_exc(rsp_exc), .rsp_last(rsp_last),
    .rsp_func(rsp_func), .rsp_code(rsp_code), .rsp_data(rsp_data));
  function automatic logic [31:0] val(input int i);
    return {16'h4100 + 16'(i), 16'h0F00 + 16'(i)};
  endfunction
  task automatic step();
    @(posedge sys_clk);
    #2;
  endtask
  // one transfer, code 0 means a data answer
  task automatic xq(input logic p, input logic [7:0] f, input logic [15:0] s,
    input logic [15:0] c, input logic [7:0] code);
    n_req++;
    i_mmvb_master.xfer(p, f, s, c);
    `CHK(i_mmvb_master.got_port, p)
    `CHK(i_mmvb_master.got_exc, code != 8'h00)
    `CHK(i_mmvb_master.got_code, code)
    `CHK(i_mmvb_master.got_func, (code != 8'h00) ? (f | mmvb_pkg::EXC_FLAG) : f)
    if (code != 8'h00) begin
      n_exc++;
      `CHK(i_mmvb_master.beats.size(), 1)
    end else begin
      `CHK(i_mmvb_master.beats.size(), int'(c))
    end
  endtask
  task automatic chk_rd(input int idx, input int n);
    logic [31:0] w;
    for (int k = 0; k < n; k++) begin
      w = val(idx + k / 2);
      `CHK(i_mmvb_master.beats[k], (k % 2) ? w[15:0] : w[31:31-15])
    end
  endtask
  task automatic pe(input logic sup, res, unc, tim, input logic [2:0] exp_flags);
    val_unc = unc;
    time_unc = tim;
    step();
    val_unc = 1'h0;
    time_unc = 1'h0;
    period_end = 1'h1;
    cut_supply = sup;
    cut_resync = res;
    step();
    period_end = 1'h0;
    cut_supply = 1'h0;
    cut_resync = 1'h0;
    `CHK(strobe, 1'h1)
    `CHK(flags, exp_flags)
    step();
    `CHK(strobe, 1'h0)
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #(5000 * 50);
    n_fail++;
    print_verdict();
  end
  initial begin
    {rst, meas_we, period_end, cut_supply, cut_resync, val_unc, time_unc} = 7'h40;
    meas_idx = 6'h00;
    meas_data = 32'h0;
    repeat (6) @(posedge sys_clk);
    #2;
    rst = 1'h0;
    `CHK(flags, 3'h0)
    `CHK(req_total, 16'h0000)
    meas_we = 1'h1;
    foreach (ids[j]) begin
      meas_idx = 6'(ids[j]);
      meas_data = val(ids[j]);
      step();
    end
    meas_we = 1'h0;
    i_mmvb_master.slow = 1'h1;
    xq(1'h0, mmvb_pkg::FC_READ_HOLD, 16'h0001, 16'h0006, 8'h00);
    chk_rd(0, 6);
    i_mmvb_master.slow = 1'h0;
    xq(1'h1, mmvb_pkg::FC_READ_INPUT, 16'h005F, 16'h0002, 8'h00);
    chk_rd(47, 2);
    xq(1'h1, mmvb_pkg::FC_READ_HOLD, 16'h0031, 16'h0002, 8'h00);
    `CHK({i_mmvb_master.beats[0], i_mmvb_master.beats[1]}, 32'h0)
    xq(1'h0, mmvb_pkg::FC_READ_HOLD, 16'h0002, 16'h0002, 8'h02);
    xq(1'h1, mmvb_pkg::FC_READ_INPUT, 16'h0038, 16'h0001, 8'h02);
    xq(1'h0, mmvb_pkg::FC_WRITE_MULTI, 16'h0001, 16'h0003, 8'h02);
    xq(1'h1, mmvb_pkg::FC_WRITE_SINGLE, 16'h0001, 16'h0001, 8'h02);
    xq(1'h1, mmvb_pkg::FC_WRITE_MULTI, 16'h0001, 16'h0002, 8'h01);
    xq(1'h0, 8'h05, 16'h0001, 16'h0002, 8'h01);
    xq(1'h0, mmvb_pkg::FC_READ_HOLD, 16'h005F, 16'h0004, 8'h02);
    xq(1'h0, mmvb_pkg::FC_READ_HOLD, 16'h0001, 16'h0000, 8'h03);
    xq(1'h0, mmvb_pkg::FC_READ_INPUT, 16'h0001, 16'h0002, 8'h00);
    chk_rd(0, 2);
    pe(1'h1, 1'h0, 1'h1, 1'h0, 3'h3);
    pe(1'h0, 1'h0, 1'h0, 1'h1, 3'h4);
    pe(1'h0, 1'h1, 1'h0, 1'h0, 3'h4);
    pe(1'h0, 1'h0, 1'h0, 1'h0, 3'h0);
    `CHK(req_total, 16'(n_req))
    `CHK(exc_total, 16'(n_exc))
    print_verdict();
  end
endmodule
